// ==== pkg/line_amp_power_save_map.svh ====
// Register offsets, field positions, reset values and timing counts
// for the line-out power and clock sequencer.
// Assumes inclusion by bare name from design files.
`ifndef LINE_AMP_POWER_SAVE_MAP_SVH
`define LINE_AMP_POWER_SAVE_MAP_SVH

// Register offsets (byte addresses on the control port)
`define LINE_AMP_POWER_SAVE_ADDR_PLL_CLK      8'h01
`define LINE_AMP_POWER_SAVE_ADDR_LEFT_IN_VOL  8'h09
`define LINE_AMP_POWER_SAVE_ADDR_LEFT_OUT_VOL 8'h0A
`define LINE_AMP_POWER_SAVE_ADDR_RIGHT_IN_VOL 8'h0C
`define LINE_AMP_POWER_SAVE_ADDR_RIGHT_OUT_VOL 8'h0D

// Field positions within the clock control register
`define LINE_AMP_POWER_SAVE_BIT_PLL_POWER     0
`define LINE_AMP_POWER_SAVE_BIT_CLK_OUT_EN    1

// Reset values
`define LINE_AMP_POWER_SAVE_RST_PLL_CLK       8'h00
`define LINE_AMP_POWER_SAVE_RST_IN_VOL        8'h91
`define LINE_AMP_POWER_SAVE_RST_OUT_VOL       8'h18
`define LINE_AMP_POWER_SAVE_VOL_0DB           8'h18

// Initialization period in sample periods
`define LINE_AMP_POWER_SAVE_INIT_FRAMES       11'h423

`endif

// ==== pkg/line_amp_power_save_pkg.sv ====
// Types shared by the line-out sequencer design files.
// Assumes nothing beyond a SystemVerilog compiler.
package line_amp_power_save_pkg;
    // Initialization state of the DAC path
    typedef enum logic [1:0]
    {
        LINE_AMP_POWER_SAVE_IDLE,
        LINE_AMP_POWER_SAVE_INIT,
        LINE_AMP_POWER_SAVE_RUN
    } line_amp_power_save_state_t;
endpackage

// ==== verification/line_amp_power_save_host_model.sv ====
// Host model: register writes, power bits and frame clock, in the
// order a careful host uses them.
// Assumes clk_sys is shared with the sequencer; waits are scaled.
`timescale 1ns/100ps
`default_nettype none
module line_amp_power_save_host_model
#(
    parameter int WAIT_CYC = 40
)
(
    input  wire logic       clk_sys,
    output logic            reg_wr,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            dac_power,
    output logic            mixer_amp_power,
    output logic            line_amp_power,
    output logic            line_amp_power_save,
    output logic            dac_to_line_path,
    output logic            audio_frame_clock
);
    logic frame_run = 1'b1; // Clocks supplied
    int   half_cnt  = 0;    // Frame half-period count

    initial
    begin
        {reg_wr, reg_addr, reg_wdata, audio_frame_clock} = '0;
        {dac_power, mixer_amp_power, line_amp_power} = '0;
        {line_amp_power_save, dac_to_line_path} = '0;
    end

    // Frame clock, 40 cycles a frame, parked low once stopped
    always @(negedge clk_sys)
    begin
        half_cnt = (half_cnt + 1) % 20;
        if (!frame_run)
            audio_frame_clock <= 1'b0;
        else if (half_cnt == 0)
            audio_frame_clock <= ~audio_frame_clock;
    end

    // One write; a gap follows so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    // Present a read address
    task automatic point(input logic [7:0] a);
        @(negedge clk_sys);
        reg_addr = a;
    endtask

    // Worst-case wait timer, scaled down for simulation
    task automatic hold_off();
        repeat (WAIT_CYC) @(negedge clk_sys);
    endtask

    // Power-up: lock wait, path, volumes, save mode, power together
    task automatic power_up(input logic [7:0] lv, input logic [7:0] rv);
        hold_off();
        @(negedge clk_sys);
        dac_to_line_path = 1'b1;
        wr(8'h09, 8'h91);
        wr(8'h0C, 8'h91);
        wr(8'h0A, lv);
        wr(8'h0D, rv);
        @(negedge clk_sys);
        line_amp_power_save = 1'b1;
        @(negedge clk_sys);
        {dac_power, mixer_amp_power, line_amp_power} = '1;
    endtask

    // Leave save mode only after outputs have settled
    task automatic release_save();
        hold_off();
        @(negedge clk_sys);
        line_amp_power_save = 1'b0;
    endtask

    // Power-down: save mode, power off together, path off
    task automatic power_down();
        @(negedge clk_sys);
        line_amp_power_save = 1'b1;
        @(negedge clk_sys);
        {dac_power, mixer_amp_power, line_amp_power} = '0;
        @(negedge clk_sys);
        dac_to_line_path = 1'b0;
        release_save();
    endtask

    // Clock stop, used only while the DAC is off
    task automatic clock_stop(input logic master);
        if (master)
            wr(8'h01, 8'h02);
        wr(8'h01, 8'h00);
        #1 frame_run = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verification/line_amp_power_save_seq_tb.sv ====
// Testbench for the line-out sequencer: samples and level bits here,
// registers and power order through the host model.
// Assumes the register map header is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "line_amp_power_save_map.svh"
module line_amp_power_save_seq_tb;
    localparam int INIT_N = 4;  // Shortened init length
    localparam int FRAME  = 40; // Clocks per frame
    typedef struct {int s; logic [23:0] v;} line_amp_power_save_exp_t;

    logic        clk_sys, nrst, reg_wr, dac_power, mixer_amp_power;
    logic        line_amp_power, line_amp_power_save, dac_to_line_path;
    logic        left_adc_power, right_adc_power, common_volume_control;
    logic        alc_enable, audio_frame_clock, init_busy, alc_run;
    logic        pll_power, clock_output_enable, line_amp_active;
    logic        line_amp_saving;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, left_out_gain, tv, d;
    logic [7:0]  right_out_gain, alc_left_start, alc_right_start, prev_g;
    logic [23:0] left_sample_in, right_sample_in, smp;
    logic [23:0] left_dac_data, right_dac_data;
    int          error_cnt = 0, n_tests = 0, cyc = 0, busy_len = 0;
    line_amp_power_save_exp_t   exp_q[$], cur;

    line_amp_power_save_seq #(.INIT_LEN(INIT_N)) u_dut
    (
        .clk_sys, .nrst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .dac_power, .mixer_amp_power, .line_amp_power,
        .line_amp_power_save, .dac_to_line_path, .left_adc_power,
        .right_adc_power, .common_volume_control, .alc_enable,
        .audio_frame_clock, .left_sample_in, .right_sample_in,
        .left_dac_data, .right_dac_data, .left_out_gain,
        .right_out_gain, .alc_run, .alc_left_start, .alc_right_start,
        .init_busy, .pll_power, .clock_output_enable, .line_amp_active,
        .line_amp_saving
    );

    line_amp_power_save_host_model #(.WAIT_CYC(FRAME)) u_host
    (
        .clk_sys, .reg_wr, .reg_addr, .reg_wdata, .dac_power,
        .mixer_amp_power, .line_amp_power, .line_amp_power_save,
        .dac_to_line_path, .audio_frame_clock
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Output selected by a queued note
    function automatic logic [23:0] pick(input int s);
        case (s)
            0: return {16'h0000, reg_rdata};
            1: return left_dac_data;
            2: return right_dac_data;
            3: return {23'h0, init_busy};
            4: return {23'h0, alc_run};
            5: return {8'h00, alc_left_start, alc_right_start};
            6: return {8'h00, left_out_gain, right_out_gain};
            7: return {20'h0, pll_power, clock_output_enable,
                       line_amp_active, line_amp_saving};
            default: return {23'h0, busy_len >= (INIT_N - 1) * FRAME
                                    && busy_len <= INIT_N * FRAME + 6};
        endcase
    endfunction

    // Queue a note; the watcher compares after the next edge
    task automatic chk(input int s, input logic [23:0] v);
        exp_q.push_back('{s, v});
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        u_host.point(a);
        @(negedge clk_sys);
        chk(0, {16'h0000, v});
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watcher: takes every queued note, oldest first, once outputs have settled
    always @(posedge clk_sys)
    begin
        #1;
        while (exp_q.size() > 0)
        begin
            cur = exp_q.pop_front();
            n_tests++;
            if (pick(cur.s) !== cur.v)
            begin
                error_cnt++;
                $display("MISMATCH t=%0t sel %0d got %h exp %h", $time,
                         cur.s, pick(cur.s), cur.v);
            end
        end
    end

    // Gain steps one code at a time while powered; power-off parks it
    always @(posedge clk_sys)
    begin
        #1;
        if (nrst && dac_power === 1'b1 && left_out_gain !== prev_g)
        begin
            n_tests++;
            d = 8'(left_out_gain - prev_g + 8'h01);
            if (!(d === 8'h00 || d === 8'h02) || (common_volume_control
                && right_out_gain !== left_out_gain))
            begin
                error_cnt++;
                $display("MISMATCH t=%0t gain step %h", $time, left_out_gain);
            end
        end
        prev_g = left_out_gain;
    end

    // Init length in clocks; cleared whenever the DAC is off
    always @(posedge clk_sys)
        busy_len <= !dac_power ? 0 : busy_len + int'(init_busy === 1'b1);

    // Hang guard, far above the expected run length
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            report_and_stop();
        end
    end

    initial
    begin
        nrst = 1'b0;
        {left_adc_power, right_adc_power} = 2'b00;
        {common_volume_control, alc_enable} = 2'b11;
        {left_sample_in, right_sample_in} = '0;
        void'($urandom(12378));
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        // Reset values, unmapped place, random write
        rd(8'h01, `LINE_AMP_POWER_SAVE_RST_PLL_CLK);
        rd(8'h09, `LINE_AMP_POWER_SAVE_RST_IN_VOL);
        rd(8'h0A, `LINE_AMP_POWER_SAVE_RST_OUT_VOL);
        rd(8'h0C, `LINE_AMP_POWER_SAVE_RST_IN_VOL);
        rd(8'h0D, `LINE_AMP_POWER_SAVE_RST_OUT_VOL);
        d = 8'($urandom);
        u_host.wr(8'h55, d);
        rd(8'h55, 8'h00);
        u_host.wr(8'h0C, d);
        rd(8'h0C, d);
        chk(6, {8'h00, `LINE_AMP_POWER_SAVE_VOL_0DB, `LINE_AMP_POWER_SAVE_VOL_0DB});
        $display("test registers done");
        // Full init with random samples and volume
        smp = 24'($urandom);
        {left_sample_in, right_sample_in} = {smp, ~smp};
        tv = 8'h19 + 8'($urandom % 7);
        u_host.power_up(tv, 8'h40);
        repeat (2) @(negedge clk_sys);
        chk(3, 24'h1);
        chk(1, 24'h0);
        chk(2, 24'h0);
        chk(4, 24'h0);
        chk(5, 24'h9191);
        chk(7, 24'h3);
        for (int k = 0; k < 1000 && init_busy !== 1'b0; k++)
            @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
        chk(8, 24'h1);
        chk(1, smp);
        chk(2, ~smp);
        chk(4, 24'h1);
        chk(5, 24'h9191);
        repeat (8 * FRAME) @(negedge clk_sys);
        chk(6, {8'h00, tv, tv});
        // Separate volumes: right side heads for its own setting
        common_volume_control = 1'b0;
        repeat (40 * FRAME) @(negedge clk_sys);
        chk(6, {8'h00, tv, 8'h40});
        common_volume_control = 1'b1;
        u_host.release_save();
        chk(7, 24'h2);
        u_host.power_down();
        chk(7, 24'h0);
        chk(1, 24'h0);
        $display("test init done");
        // Abort with no converter on, skip with either one on
        for (int a = 0; a < 4; a++)
        begin
            {left_adc_power, right_adc_power} = 2'(a);
            u_host.power_up(8'h18, 8'h18);
            repeat (3) @(negedge clk_sys);
            chk(3, 24'(a == 0));
            chk(1, a == 0 ? 24'h0 : smp);
            chk(4, 24'(a != 0));
            u_host.power_down();
            chk(3, 24'h0);
            chk(1, 24'h0);
        end
        $display("test skip done");
        // Clock stop, master order then slave order
        u_host.wr(8'h01, 8'h03);
        rd(8'h01, 8'h03);
        chk(7, 24'hC);
        u_host.clock_stop(1'b1);
        rd(8'h01, 8'h00);
        chk(7, 24'h0);
        u_host.frame_run = 1'b1;
        u_host.wr(8'h01, 8'h03);
        u_host.clock_stop(1'b0);
        rd(8'h01, 8'h00);
        $display("test clock stop done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== verilog/line_amp_power_save_seq.sv ====
// Line-out power and clock sequencer: register file, DAC init
// period, sample zeroing, level-control hold, and volume ramp.
// Assumes a register write port on clk_sys and a frame clock pin.
//
// Overview of operation
// R1 - DAC power rise, no ADC: 1059-frame init
// R2 - Init period forces both samples to zero
// R3 - After init, real samples pass through
// R4 - Any ADC powered: init is skipped
// R5 - Level control held at input volume
// R6 - Level control restarts from input volume
// R7 - Host sets input volumes 91H without ADC
// R8 - Common volume bit: left volume both sides
// R9 - Output volume ramps softly from 0 dB
// R10 - Host waits PLL lock before power-up
// R11 - Host follows power-up write order
// R12 - Host clears power-save after outputs settle
// R13 - Host follows power-down write order
// R14 - Host clears power-save after outputs fall
// R15 - Master clock stops only when idle
// R16 - PLL master: PLL off, clock out, clock
// R17 - PLL slave frame/bit: write 00H first
// R18 - PLL slave master-pin: write 00H first
// R19 - Then master clock stops last
// R20 - Host timers cover every required wait
`timescale 1ns/100ps
`default_nettype none
`include "line_amp_power_save_map.svh"
module line_amp_power_save_seq
#(
    parameter int DW        = 24,
    parameter int INIT_LEN  = `LINE_AMP_POWER_SAVE_INIT_FRAMES
)
(
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic          reg_wr,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic      [7:0]    reg_rdata,
    input  wire logic          dac_power,
    input  wire logic          mixer_amp_power,
    input  wire logic          line_amp_power,
    input  wire logic          line_amp_power_save,
    input  wire logic          dac_to_line_path,
    input  wire logic          left_adc_power,
    input  wire logic          right_adc_power,
    input  wire logic          common_volume_control,
    input  wire logic          alc_enable,
    input  wire logic          audio_frame_clock,
    input  wire logic [DW-1:0] left_sample_in,
    input  wire logic [DW-1:0] right_sample_in,
    output logic      [DW-1:0] left_dac_data,
    output logic      [DW-1:0] right_dac_data,
    output logic      [7:0]    left_out_gain,
    output logic      [7:0]    right_out_gain,
    output logic               alc_run,
    output logic      [7:0]    alc_left_start,
    output logic      [7:0]    alc_right_start,
    output logic               init_busy,
    output logic               pll_power,
    output logic               clock_output_enable,
    output logic               line_amp_active,
    output logic               line_amp_saving
);
    import line_amp_power_save_pkg::*;

    initial
    begin
        if (INIT_LEN < 1 || INIT_LEN > 2047)
            $error("line_amp_power_save_seq: INIT_LEN out of range");
        if (DW < 16)
            $error("line_amp_power_save_seq: DW too small");
    end

    // Register file
    logic [7:0] pll_clk_r;       // PLL and clock output control
    logic [7:0] pll_clk_nxt;
    logic [7:0] lin_vol_r;       // Left input volume
    logic [7:0] lin_vol_nxt;
    logic [7:0] rin_vol_r;       // Right input volume
    logic [7:0] rin_vol_nxt;
    logic [7:0] left_line_output_vol_r;      // Left output volume
    logic [7:0] left_line_output_vol_nxt;
    logic [7:0] right_line_output_vol_r;      // Right output volume
    logic [7:0] right_line_output_vol_nxt;
    logic [7:0] rdata_r;         // Registered read data
    logic [7:0] rdata_nxt;

    // Write decode and read mux
    always_comb
    begin
        pll_clk_nxt  = pll_clk_r;
        lin_vol_nxt  = lin_vol_r;
        rin_vol_nxt  = rin_vol_r;
        left_line_output_vol_nxt = left_line_output_vol_r;
        right_line_output_vol_nxt = right_line_output_vol_r;
        if (reg_wr)
        begin
            case (reg_addr)
                `LINE_AMP_POWER_SAVE_ADDR_PLL_CLK:       pll_clk_nxt  = reg_wdata;
                `LINE_AMP_POWER_SAVE_ADDR_LEFT_IN_VOL:   lin_vol_nxt  = reg_wdata;
                `LINE_AMP_POWER_SAVE_ADDR_RIGHT_IN_VOL:  rin_vol_nxt  = reg_wdata;
                `LINE_AMP_POWER_SAVE_ADDR_LEFT_OUT_VOL:  left_line_output_vol_nxt = reg_wdata;
                `LINE_AMP_POWER_SAVE_ADDR_RIGHT_OUT_VOL: right_line_output_vol_nxt = reg_wdata;
                default:                  ;  // Unmapped write ignored
            endcase
        end
        case (reg_addr)
            `LINE_AMP_POWER_SAVE_ADDR_PLL_CLK:       rdata_nxt = pll_clk_r;
            `LINE_AMP_POWER_SAVE_ADDR_LEFT_IN_VOL:   rdata_nxt = lin_vol_r;
            `LINE_AMP_POWER_SAVE_ADDR_RIGHT_IN_VOL:  rdata_nxt = rin_vol_r;
            `LINE_AMP_POWER_SAVE_ADDR_LEFT_OUT_VOL:  rdata_nxt = left_line_output_vol_r;
            `LINE_AMP_POWER_SAVE_ADDR_RIGHT_OUT_VOL: rdata_nxt = right_line_output_vol_r;
            default:                  rdata_nxt = 8'h00;
        endcase
    end

    // Register storage
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pll_clk_r  <= `LINE_AMP_POWER_SAVE_RST_PLL_CLK;
            lin_vol_r  <= `LINE_AMP_POWER_SAVE_RST_IN_VOL;
            rin_vol_r  <= `LINE_AMP_POWER_SAVE_RST_IN_VOL;
            left_line_output_vol_r <= `LINE_AMP_POWER_SAVE_RST_OUT_VOL;
            right_line_output_vol_r <= `LINE_AMP_POWER_SAVE_RST_OUT_VOL;
            rdata_r    <= 8'h00;
        end
        else
        begin
            pll_clk_r  <= pll_clk_nxt;
            lin_vol_r  <= lin_vol_nxt;
            rin_vol_r  <= rin_vol_nxt;
            left_line_output_vol_r <= left_line_output_vol_nxt;
            right_line_output_vol_r <= right_line_output_vol_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // Frame clock synchroniser; first stage feeds only the second
    logic fck_s1_r;
    logic fck_s2_r;
    logic fck_s3_r;   // Edge history, reads only the second stage
    logic frame_tick; // One pulse per sample period

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            fck_s1_r <= 1'b0;
            fck_s2_r <= 1'b0;
            fck_s3_r <= 1'b0;
        end
        else
        begin
            fck_s1_r <= audio_frame_clock;
            fck_s2_r <= fck_s1_r;
            fck_s3_r <= fck_s2_r;
        end
    end

    assign frame_tick = fck_s2_r & ~fck_s3_r;

    // Init sequencer state
    line_amp_power_save_state_t st_r;
    line_amp_power_save_state_t st_nxt;
    logic [10:0] cnt_r;        // Frames left in the init period
    logic [10:0] cnt_nxt;
    logic        dac_pwr_d_r;  // Previous DAC power level
    logic        adc_any;

    assign adc_any = left_adc_power | right_adc_power;

    // Init period control; counts frames, not system cycles
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            LINE_AMP_POWER_SAVE_IDLE:
            begin
                if (dac_power && !dac_pwr_d_r && !adc_any)
                begin
                    st_nxt  = LINE_AMP_POWER_SAVE_INIT;              // R1
                    cnt_nxt = 11'(INIT_LEN);          // R1
                end
                else if (dac_power)
                    st_nxt = LINE_AMP_POWER_SAVE_RUN;                // R4
            end
            LINE_AMP_POWER_SAVE_INIT:
            begin
                if (!dac_power)
                    st_nxt = LINE_AMP_POWER_SAVE_IDLE;
                else if (frame_tick)
                begin
                    cnt_nxt = cnt_r - 11'd1;
                    if (cnt_r == 11'd1)
                        st_nxt = LINE_AMP_POWER_SAVE_RUN;            // R3
                end
            end
            LINE_AMP_POWER_SAVE_RUN:
            begin
                if (!dac_power)
                    st_nxt = LINE_AMP_POWER_SAVE_IDLE;
            end
            default:
                st_nxt = LINE_AMP_POWER_SAVE_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r        <= LINE_AMP_POWER_SAVE_IDLE;
            cnt_r       <= 11'h000;
            dac_pwr_d_r <= 1'b0;
        end
        else
        begin
            st_r        <= st_nxt;
            cnt_r       <= cnt_nxt;
            dac_pwr_d_r <= dac_power;
        end
    end

    // Sample path, registered
    logic [DW-1:0] ldat_r;
    logic [DW-1:0] ldat_nxt;
    logic [DW-1:0] rdat_r;
    logic [DW-1:0] rdat_nxt;
    logic          alc_run_r;
    logic          alc_run_nxt;

    // Zero both channels in idle and init; pass only in run
    always_comb
    begin
        if (st_r == LINE_AMP_POWER_SAVE_RUN)
        begin
            ldat_nxt = left_sample_in;    // R3
            rdat_nxt = right_sample_in;   // R3
        end
        else
        begin
            ldat_nxt = '0;                // R2
            rdat_nxt = '0;                // R2
        end
        // Level control only runs once init is over
        alc_run_nxt = alc_enable && (st_r == LINE_AMP_POWER_SAVE_RUN);  // R5
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ldat_r    <= '0;
            rdat_r    <= '0;
            alc_run_r <= 1'b0;
        end
        else
        begin
            ldat_r    <= ldat_nxt;
            rdat_r    <= rdat_nxt;
            alc_run_r <= alc_run_nxt;
        end
    end

    // Volume ramps; common control steers both from left
    logic [7:0] rtarget;
    logic       ramp_en;
    assign rtarget = common_volume_control ? left_line_output_vol_r : right_line_output_vol_r; // R8
    assign ramp_en = dac_power;

    line_amp_power_save_vol_ramp #(.W(8)) u_ramp_l
    (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .enable     (ramp_en),
        .frame_tick (frame_tick),
        .target     (left_line_output_vol_r),
        .start_val  (`LINE_AMP_POWER_SAVE_VOL_0DB),
        .gain       (left_out_gain)
    );

    line_amp_power_save_vol_ramp #(.W(8)) u_ramp_r
    (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .enable     (ramp_en),
        .frame_tick (frame_tick),
        .target     (rtarget),
        .start_val  (`LINE_AMP_POWER_SAVE_VOL_0DB),
        .gain       (right_out_gain)
    );

    // Outputs
    assign reg_rdata           = rdata_r;
    assign left_dac_data       = ldat_r;
    assign right_dac_data      = rdat_r;
    assign alc_run             = alc_run_r;
    assign alc_left_start      = lin_vol_r;  // R6
    assign alc_right_start     = rin_vol_r;  // R6
    assign init_busy           = (st_r == LINE_AMP_POWER_SAVE_INIT);
    assign pll_power           = pll_clk_r[`LINE_AMP_POWER_SAVE_BIT_PLL_POWER];
    assign clock_output_enable = pll_clk_r[`LINE_AMP_POWER_SAVE_BIT_CLK_OUT_EN];
    assign line_amp_active     = line_amp_power & mixer_amp_power
                               & dac_to_line_path;
    assign line_amp_saving     = line_amp_power_save;

    AST_INIT_START: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_IDLE && dac_power && !dac_pwr_d_r && !adc_any
        |=> st_r == LINE_AMP_POWER_SAVE_INIT && cnt_r == 11'(INIT_LEN))  // R1
        else $error("Init period not started");
    AST_INIT_ZERO: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_INIT |=> ldat_r == '0 && rdat_r == '0)  // R2
        else $error("Samples not zeroed in init");
    AST_PASS: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_RUN |=> ldat_r == $past(left_sample_in))  // R3
        else $error("Samples not passed after init");
    AST_SKIP: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_IDLE && dac_power && adc_any |=> st_r == LINE_AMP_POWER_SAVE_RUN)  // R4
        else $error("Init not skipped with ADC on");
    AST_ALC_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_INIT |=> !alc_run_r)  // R5
        else $error("Level control ran during init");
    AST_ALC_START: assert property (@(posedge clk_sys) disable iff (!nrst)
        alc_run_r |-> alc_left_start == lin_vol_r
                   && alc_right_start == rin_vol_r)  // R6
        else $error("Level control start gain wrong");
    // Equal gains stay equal while both sides share the left target
    AST_COMMON: assert property (@(posedge clk_sys) disable iff (!nrst)
        common_volume_control && right_out_gain == left_out_gain
        |=> right_out_gain == left_out_gain)  // R8
        else $error("Common volume not applied");
    AST_RAMP_0DB: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(dac_power) |-> left_out_gain == `LINE_AMP_POWER_SAVE_VOL_0DB)  // R9
        else $error("Ramp did not start at 0 dB");
    COV_INIT_DONE: cover property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_INIT ##1 st_r == LINE_AMP_POWER_SAVE_RUN);
    COV_SKIP: cover property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_IDLE ##1 st_r == LINE_AMP_POWER_SAVE_RUN);
    COV_ABORT: cover property (@(posedge clk_sys) disable iff (!nrst)
        st_r == LINE_AMP_POWER_SAVE_INIT ##1 st_r == LINE_AMP_POWER_SAVE_IDLE);
endmodule
`default_nettype wire

// ==== verilog/line_amp_power_save_vol_ramp.sv ====
// Soft volume ramp: steps a gain value one code per sample period
// toward a target, starting from the 0 dB code after power-up.
// Assumes frame_tick is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "line_amp_power_save_map.svh"
module line_amp_power_save_vol_ramp
#(
    parameter int W = 8
)
(
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         enable,
    input  wire logic         frame_tick,
    input  wire logic [W-1:0] target,
    input  wire logic [W-1:0] start_val,
    output logic      [W-1:0] gain
);
    import line_amp_power_save_pkg::*;

    initial
    begin
        if (W < 2)
            $error("line_amp_power_save_vol_ramp: W too small");
    end

    logic [W-1:0] gain_r;   // Current gain
    logic [W-1:0] gain_nxt; // Next gain

    // One code per frame; while disabled, park at start value
    always_comb
    begin
        gain_nxt = gain_r;
        if (!enable)
            gain_nxt = start_val;   // R9
        else if (frame_tick && gain_r < target)
            gain_nxt = gain_r + W'(1);  // R9
        else if (frame_tick && gain_r > target)
            gain_nxt = gain_r - W'(1);  // R9
    end

    // Register only
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            gain_r <= `LINE_AMP_POWER_SAVE_VOL_0DB;
        else
            gain_r <= gain_nxt;
    end

    assign gain = gain_r;

    AST_RAMP_STEP: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(enable) && enable |->
        (gain_r - $past(gain_r) <= W'(1)) ||
        ($past(gain_r) - gain_r <= W'(1)))  // R9
        else $error("Ramp jumped more than one step");
endmodule
`default_nettype wire
